// ==== hw/fbrr_pkg.sv ====
// Shared constants, types and helpers of the remote register handshake
package fbrr_pkg;
	localparam int            N_AXES    = 2;
	localparam int            WORD_W    = 16;
	localparam int            POS_W     = 32;
	localparam int            WPA       = 4;
	localparam int            ADR_W     = 8;
	localparam int            W_CMD     = 0;
	localparam int            W_ADR     = 1;
	localparam int            W_LO      = 2;
	localparam int            W_HI      = 3;
	localparam int            BITS_PA   = 4;
	localparam int            CB_DREQ   = 0;
	localparam int            CB_WREQ   = 1;
	localparam int            CB_RREQ   = 2;
	localparam int            CB_START  = 3;
	localparam int            SB_DEND   = 0;
	localparam int            SB_WACT   = 1;
	localparam int            SB_RACT   = 2;
	localparam int            SB_MOVE   = 3;
	localparam logic [15:0]   CMD_PPRESET = 16'h30c5;
	localparam logic [31:0]   EXEC_DATA   = 32'h0000_0001;
	localparam logic [7:0]    OFS_WWORD = 8'h00;
	localparam logic [7:0]    OFS_CTRL  = 8'h20;
	localparam logic [7:0]    OFS_STAT  = 8'h24;
	localparam logic [7:0]    OFS_RWORD = 8'h40;
	localparam logic [31:0]   POS_RST   = 32'h0000_0000;
	localparam logic [15:0]   WORD_RST  = 16'h0000;
	localparam logic [31:0]   BUS_ZERO  = 32'h0000_0000;

	typedef enum logic [1:0] {
		CMD_IDLE = 2'b01,
		CMD_END  = 2'b10
	} fbrr_cmd_e;

	typedef enum logic [1:0] {
		MV_IDLE = 2'b01,
		MV_RUN  = 2'b10
	} fbrr_mv_e;

	function automatic logic [31:0] fbrr_join(input logic [15:0] hi,
		input logic [15:0] lo);
		return {hi, lo};
	endfunction

	function automatic logic fbrr_hit(input logic [7:0] adr,
		input logic [7:0] base, input int idx);
		return adr == 8'(int'(base) + idx * 4);
	endfunction
endpackage

// ==== hw/fbrr_reg_if.sv ====
// Register side to core side bundle of the remote register handshake
`timescale 1ns/1ps
interface fbrr_reg_if #(parameter int N_AX = fbrr_pkg::N_AXES);
	logic [15:0]     master_write_word    [N_AX*4];
	logic [15:0]     converter_read_word  [N_AX*4];
	logic [N_AX-1:0] d_req;
	logic [N_AX-1:0] wr_req;
	logic [N_AX-1:0] rd_req;
	logic [N_AX-1:0] start;
	logic [N_AX-1:0] d_end;
	logic [N_AX-1:0] position_write_active;
	logic [N_AX-1:0] monitor_read_active;
	logic [N_AX-1:0] moving;

	modport regs (
		output master_write_word, d_req, wr_req, rd_req, start,
		input  converter_read_word, d_end, position_write_active,
		input  monitor_read_active, moving
	);
	modport core (
		input  master_write_word, d_req, wr_req, rd_req, start,
		output converter_read_word, d_end, position_write_active,
		output monitor_read_active, moving
	);
endinterface

// ==== hw/fbrr_wb_regs.sv ====
// Wishbone classic slave holding the write words and request bits
`timescale 1ns/1ps
module fbrr_wb_regs #(
	parameter int N_AX = fbrr_pkg::N_AXES
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        cyc_i,
	input  wire logic        stb_i,
	input  wire logic        we_i,
	input  wire logic [7:0]  adr_i,
	input  wire logic [3:0]  sel_i,
	input  wire logic [31:0] dat_i,
	output logic      [31:0] dat_o,
	output logic             ack_o,
	fbrr_reg_if.regs         rif
);
	import fbrr_pkg::*;

	localparam int NW = N_AX * WPA;
	localparam int CW = N_AX * BITS_PA;

	logic [15:0]   wword_q [NW];
	logic [CW-1:0] ctrl_q;
	logic [CW-1:0] stat;
	logic          ack_q;
	logic [31:0]   dat_q;
	logic [31:0]   rdata;
	logic          req;
	logic          wr_go;

	assign req   = cyc_i & stb_i;
	assign wr_go = req & we_i & ack_q;
	assign ack_o = ack_q;
	assign dat_o = dat_q;

	// ----------------------------------------------------------------
	// Bus handshake
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ack_q <= 1'b0;
		else
			ack_q <= req & ~ack_q;
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			dat_q <= BUS_ZERO;
		else if (req & ~ack_q & ~we_i)
			dat_q <= rdata;
	end

	// ----------------------------------------------------------------
	// Writable registers, taken at the edge the master sees ack
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		for (int i = 0; i < NW; i++)
		begin
			if (rst_i)
				wword_q[i] <= WORD_RST;
			else if (wr_go && fbrr_hit(adr_i, OFS_WWORD, i))
			begin
				if (sel_i[0])
					wword_q[i][7:0] <= dat_i[7:0];
				if (sel_i[1])
					wword_q[i][15:8] <= dat_i[15:8];
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			ctrl_q <= '0;
		else if (wr_go && adr_i == OFS_CTRL && sel_i[0])
			ctrl_q <= dat_i[CW-1:0];
	end

	// ----------------------------------------------------------------
	// Read mux and fan-out to the core
	// ----------------------------------------------------------------
	always_comb
	begin
		rdata = BUS_ZERO;
		for (int a = 0; a < N_AX; a++)
		begin
			stat[a*BITS_PA+SB_DEND] = rif.d_end[a];
			stat[a*BITS_PA+SB_WACT] = rif.position_write_active[a];
			stat[a*BITS_PA+SB_RACT] = rif.monitor_read_active[a];
			stat[a*BITS_PA+SB_MOVE] = rif.moving[a];
			rif.d_req[a]  = ctrl_q[a*BITS_PA+CB_DREQ];
			rif.wr_req[a] = ctrl_q[a*BITS_PA+CB_WREQ];
			rif.rd_req[a] = ctrl_q[a*BITS_PA+CB_RREQ];
			rif.start[a]  = ctrl_q[a*BITS_PA+CB_START];
		end
		for (int i = 0; i < NW; i++)
		begin
			rif.master_write_word[i] = wword_q[i];
			if (fbrr_hit(adr_i, OFS_WWORD, i))
				rdata = {16'h0000, wword_q[i]};
			if (fbrr_hit(adr_i, OFS_RWORD, i))
				rdata = {16'h0000, rif.converter_read_word[i]};
		end
		if (adr_i == OFS_CTRL)
			rdata = 32'(ctrl_q);
		if (adr_i == OFS_STAT)
			rdata = 32'(stat);
	end
endmodule // fbrr_wb_regs

// ==== hw/fbrr_top.sv ====
// Remote register and remote I/O handshake core for two motor axes
//
// Functional notes
// - Preset command with trigger sets that axis present position to zero.
// - Maintenance commands use code, axis number, lower and upper data.
// - Command runs only when the data words hold exactly one.
// - After processing a command write, data-end rises on its own.
// - With data-end high, read words echo code, axis and data words.
// - Read words per axis carry detection position then position No.0.
// - Read request starts monitoring; read-data response rises on its own.
// - Detection position and position No.0 refresh while read request holds.
// - Write request writes position data; write-data response then rises.
// - New position No.0 shows in read words in its storing update.
// - While write request holds, position No.0 follows the write words.
// - Master sets start to begin positioning and clears it afterwards.
// - A started move runs to its target even after start drops.
// - Moving position is reported throughout; equals target when done.
// - Clearing write or read request drops the matching response bit.
//
// Decided for this implementation: the Wishbone register port and the register addresses.
`timescale 1ns/1ps
module fbrr_top #(
	parameter int N_AX = fbrr_pkg::N_AXES
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [3:0]      wb_sel_i,
	input  wire logic [31:0]     wb_dat_i,
	output logic      [31:0]     wb_dat_o,
	output logic                 wb_ack_o,
	output logic      [N_AX-1:0] moving_o
);
	import fbrr_pkg::*;

	// ----------------------------------------------------------------
	// Storage
	// ----------------------------------------------------------------
	fbrr_reg_if #(.N_AX(N_AX)) rif ();

	fbrr_cmd_e       cst_q   [N_AX];
	fbrr_cmd_e       cst_d   [N_AX];
	fbrr_mv_e        mst_q   [N_AX];
	fbrr_mv_e        mst_d   [N_AX];
	logic [31:0]     pos_q   [N_AX];
	logic [31:0]     pos_d   [N_AX];
	logic [31:0]     pos0_q  [N_AX];
	logic [31:0]     pos0_d  [N_AX];
	logic [31:0]     tgt_q   [N_AX];
	logic [15:0]     rword_q [N_AX*4];
	logic [N_AX-1:0] start_q;
	logic [N_AX-1:0] wact_q;
	logic [N_AX-1:0] ract_q;
	logic [N_AX-1:0] exec;
	logic [N_AX-1:0] preset;
	logic [N_AX-1:0] launch;

	// ----------------------------------------------------------------
	// Bus slave
	// ----------------------------------------------------------------
	fbrr_wb_regs #(
		.N_AX (N_AX)
	) u_regs (
		.clk_i (clk_i),
		.rst_i (rst_i),
		.cyc_i (wb_cyc_i),
		.stb_i (wb_stb_i),
		.we_i  (wb_we_i),
		.adr_i (wb_adr_i),
		.sel_i (wb_sel_i),
		.dat_i (wb_dat_i),
		.dat_o (wb_dat_o),
		.ack_o (wb_ack_o),
		.rif   (rif)
	);

	// ----------------------------------------------------------------
	// Command decode
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			exec[a] = (cst_q[a] == CMD_IDLE) & rif.d_req[a];
			preset[a] = exec[a]
				&& rif.master_write_word[a*WPA+W_CMD] == CMD_PPRESET
				&& rif.master_write_word[a*WPA+W_ADR] == 16'(a)
				&& fbrr_join(rif.master_write_word[a*WPA+W_HI],
					rif.master_write_word[a*WPA+W_LO]) == EXEC_DATA;
			launch[a] = rif.start[a] & ~start_q[a];
		end
	end

	// ----------------------------------------------------------------
	// Command handshake state
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			case (cst_q[a])
				CMD_IDLE:
				begin
					if (rif.d_req[a])
						cst_d[a] = CMD_END;
					else
						cst_d[a] = CMD_IDLE;
				end
				CMD_END:
				begin
					if (!rif.d_req[a])
						cst_d[a] = CMD_IDLE;
					else
						cst_d[a] = CMD_END;
				end
				default:
					cst_d[a] = CMD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			if (rst_i)
				cst_q[a] <= CMD_IDLE;
			else
				cst_q[a] <= cst_d[a];
		end
	end

	// ----------------------------------------------------------------
	// Stored position No.0
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			if (rif.wr_req[a])
				pos0_d[a] = fbrr_join(rif.master_write_word[a*WPA+W_HI],
					rif.master_write_word[a*WPA+W_LO]);
			else
				pos0_d[a] = pos0_q[a];
		end
	end

	always_ff @(posedge clk_i)
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			if (rst_i)
				pos0_q[a] <= POS_RST;
			else
				pos0_q[a] <= pos0_d[a];
		end
	end

	// ----------------------------------------------------------------
	// Response flags
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wact_q  <= '0;
			ract_q  <= '0;
			start_q <= '0;
		end
		else
		begin
			wact_q  <= rif.wr_req;
			ract_q  <= rif.rd_req;
			start_q <= rif.start;
		end
	end

	// ----------------------------------------------------------------
	// Positioning move
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			case (mst_q[a])
				MV_IDLE:
				begin
					if (launch[a])
						mst_d[a] = MV_RUN;
					else
						mst_d[a] = MV_IDLE;
				end
				MV_RUN:
				begin
					if (pos_d[a] == tgt_q[a])
						mst_d[a] = MV_IDLE;
					else
						mst_d[a] = MV_RUN;
				end
				default:
					mst_d[a] = MV_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_i)
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			if (rst_i)
				mst_q[a] <= MV_IDLE;
			else
				mst_q[a] <= mst_d[a];
		end
	end

	always_ff @(posedge clk_i)
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			if (rst_i)
				tgt_q[a] <= POS_RST;
			else if (mst_q[a] == MV_IDLE && launch[a])
				tgt_q[a] <= pos0_q[a];
		end
	end

	// Present position steps one count per clock toward the target
	always_comb
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			pos_d[a] = pos_q[a];
			if (preset[a])
				pos_d[a] = POS_RST;
			else if (mst_q[a] == MV_RUN && pos_q[a] != tgt_q[a])
			begin
				if ($signed(tgt_q[a]) > $signed(pos_q[a]))
					pos_d[a] = 32'(pos_q[a] + 32'h0000_0001);
				else
					pos_d[a] = 32'(pos_q[a] - 32'h0000_0001);
			end
		end
	end

	always_ff @(posedge clk_i)
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			if (rst_i)
				pos_q[a] <= POS_RST;
			else
				pos_q[a] <= pos_d[a];
		end
	end

	// ----------------------------------------------------------------
	// Read words: command echo or monitor
	// ----------------------------------------------------------------
	always_ff @(posedge clk_i)
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			for (int k = 0; k < WPA; k++)
			begin
				if (rst_i)
					rword_q[a*WPA+k] <= WORD_RST;
				else if (exec[a])
					rword_q[a*WPA+k] <= rif.master_write_word[a*WPA+k];
				else if (cst_q[a] == CMD_IDLE && rif.rd_req[a])
				begin
					case (k)
						W_CMD:
							rword_q[a*WPA+k] <= pos_d[a][15:0];
						W_ADR:
							rword_q[a*WPA+k] <= pos_d[a][31:16];
						W_LO:
							rword_q[a*WPA+k] <= pos0_d[a][15:0];
						default:
							rword_q[a*WPA+k] <= pos0_d[a][31:16];
					endcase
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// Return path to the bus slave and pins
	// ----------------------------------------------------------------
	always_comb
	begin
		for (int a = 0; a < N_AX; a++)
		begin
			rif.d_end[a] = cst_q[a][1];
			rif.position_write_active[a] = wact_q[a];
			rif.monitor_read_active[a] = ract_q[a];
			rif.moving[a] = mst_q[a][1];
			moving_o[a] = mst_q[a][1];
		end
		for (int i = 0; i < N_AX * WPA; i++)
			rif.converter_read_word[i] = rword_q[i];
	end
endmodule // fbrr_top

// ==== verification/fbrr_props.sv ====
// Checker of bus timing and move launch at the top ports
`timescale 1ns/1ps
module fbrr_props
	import fbrr_pkg::*;
#(
	parameter int N_AX = N_AXES
) (
	input  wire logic            clk_i,
	input  wire logic            rst_i,
	input  wire logic            wb_cyc_i,
	input  wire logic            wb_stb_i,
	input  wire logic            wb_we_i,
	input  wire logic [7:0]      wb_adr_i,
	input  wire logic [31:0]     wb_dat_o,
	input  wire logic            wb_ack_o,
	input  wire logic [N_AX-1:0] moving_o
);
	logic ctrl_wr;

	assign ctrl_wr = wb_ack_o && wb_we_i && wb_adr_i == OFS_CTRL;

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	sequence s_req;
		wb_cyc_i && wb_stb_i && !wb_ack_o;
	endsequence
	sequence s_rd_ack;
		wb_ack_o && !wb_we_i;
	endsequence

	a_ack_latency: assert property (s_req |=> wb_ack_o)
		else $error("ack late");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack too long");
	a_no_stray: assert property (!wb_stb_i |=> !wb_ack_o)
		else $error("stray ack");
	a_ack_cause: assert property (wb_ack_o |-> $past(wb_cyc_i))
		else $error("ack without cycle");
	a_rdata_hold: assert property ($changed(wb_dat_o) |-> s_rd_ack)
		else $error("read data moved");
	a_upper_zero: assert property (s_rd_ack |-> !wb_dat_o[31:16])
		else $error("upper half set");
	a_unmapped_zero: assert property (s_rd_ack and wb_adr_i >= 8'h60
		|-> wb_dat_o == BUS_ZERO)
		else $error("unmapped read");
	a_launch_ax0: assert property ($rose(moving_o[0]) |-> $past(ctrl_wr, 2))
		else $error("axis 0 move launch");
	a_launch_ax1: assert property ($rose(moving_o[1]) |-> $past(ctrl_wr, 2))
		else $error("axis 1 move launch");
endmodule // fbrr_props

bind fbrr_top fbrr_props #(.N_AX(N_AX)) u_props (
	.clk_i, .rst_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
	.wb_dat_o, .wb_ack_o, .moving_o
);

// ==== verification/fbrr_wb_master.sv ====
// Wishbone classic master standing in for the fieldbus master
`timescale 1ns/1ps
module fbrr_wb_master (
	input  wire logic        clk_i,
	input  wire logic        ack_i,
	input  wire logic [31:0] dat_i,
	output logic             cyc_o,
	output logic             stb_o,
	output logic             we_o,
	output logic      [7:0]  adr_o,
	output logic      [3:0]  sel_o,
	output logic      [31:0] dat_o
);
	initial
	begin
		cyc_o = 1'b0;
		stb_o = 1'b0;
		we_o  = 1'b0;
		adr_o = 8'h00;
		sel_o = 4'hf;
		dat_o = 32'h0000_0000;
	end

	// Request stays put until ack is seen; idle lines show inverted data
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		@(posedge clk_i);
		cyc_o <= 1'b1;
		stb_o <= 1'b1;
		we_o  <= w;
		adr_o <= a;
		dat_o <= d;
		do
			@(posedge clk_i);
		while (ack_i !== 1'b1);
		q = dat_i;
		cyc_o <= 1'b0;
		stb_o <= 1'b0;
		adr_o <= ~a;
		dat_o <= ~d;
	endtask
endmodule // fbrr_wb_master

// ==== verification/fbrr_top_tb.sv ====
// Self-checking bench of the remote register handshake
`timescale 1ns/1ps
module fbrr_top_tb;
	import fbrr_pkg::*;
	logic              clk_i;
	logic              rst_i;
	logic              cyc;
	logic              stb;
	logic              we;
	logic [7:0]        adr;
	logic [3:0]        sel;
	logic [31:0]       dw;
	logic [31:0]       dr;
	logic              ack;
	logic [N_AXES-1:0] mv;
	int                error_cnt = 0;
	int                tests_run = 0;
	int                cycles    = 0;

	fbrr_top #(.N_AX(N_AXES)) DUT (
		.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw),
		.wb_dat_o(dr), .wb_ack_o(ack), .moving_o(mv)
	);
	fbrr_wb_master u_mst (
		.clk_i(clk_i), .ack_i(ack), .dat_i(dr), .cyc_o(cyc), .stb_o(stb),
		.we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(dw)
	);

	initial
	begin
		clk_i = 1'b0;
		forever #4 clk_i = ~clk_i;
	end

	always @(posedge clk_i)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			error_cnt++;
			close_out();
		end
	end

	task automatic close_out();
		if (error_cnt == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("wrong value t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	function automatic logic [7:0] ra(input int i);
		return 8'(i * 4);
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		u_mst.xfer(1'b1, a, d, q);
	endtask

	task automatic rc(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		u_mst.xfer(1'b0, a, BUS_ZERO, q);
		chk(q, e);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset();
		rc(OFS_CTRL, BUS_ZERO);
		rc(8'h80, BUS_ZERO);
		wr(OFS_STAT, 32'h0000_00ff);
		rc(OFS_STAT, BUS_ZERO);
	endtask

	task automatic t_monitor();
		wr(OFS_CTRL, 32'h0000_0044);
		rc(OFS_STAT, 32'h0000_0044);
		for (int i = 0; i < 8; i++)
			rc(OFS_RWORD + ra(i), BUS_ZERO);
	endtask

	task automatic t_write_pos();
		for (int a = 0; a < N_AXES; a++)
		begin
			wr(ra(4 * a + W_LO), 32'h0000_1388);
			wr(ra(4 * a + W_HI), BUS_ZERO);
		end
		wr(OFS_CTRL, 32'h0000_0066);
		rc(OFS_STAT, 32'h0000_0066);
		for (int a = 0; a < N_AXES; a++)
		begin
			rc(OFS_RWORD + ra(4 * a + W_LO), 32'h0000_1388);
			rc(OFS_RWORD + ra(4 * a), BUS_ZERO);
		end
	endtask

	task automatic t_move();
		logic [31:0] q;
		int          n;
		wr(OFS_CTRL, 32'h0000_00ee);
		wr(OFS_CTRL, 32'h0000_0066);
		chk(32'(mv), 32'h0000_0003);
		u_mst.xfer(1'b0, OFS_RWORD, BUS_ZERO, q);
		chk(32'(q > 0 && q < 32'h1388), 32'h0000_0001);
		n = 0;
		while (mv !== 2'b00 && n < 6000)
		begin
			@(posedge clk_i);
			n++;
		end
		chk(32'(mv), BUS_ZERO);
		for (int a = 0; a < N_AXES; a++)
		begin
			rc(OFS_RWORD + ra(4 * a), 32'h0000_1388);
			rc(OFS_RWORD + ra(4 * a + 1), BUS_ZERO);
		end
	endtask

	task automatic t_update();
		wr(ra(W_HI), 32'h0000_0002);
		rc(OFS_RWORD + ra(W_HI), 32'h0000_0002);
		rc(OFS_RWORD + ra(W_LO), 32'h0000_1388);
		for (int a = 0; a < N_AXES; a++)
		begin
			wr(ra(4 * a + W_LO), 32'h0000_0bb8);
			wr(ra(4 * a + W_HI), BUS_ZERO);
			rc(OFS_RWORD + ra(4 * a + W_LO), 32'h0000_0bb8);
			rc(OFS_RWORD + ra(4 * a + W_HI), BUS_ZERO);
		end
	endtask

	task automatic t_preset(input logic [31:0] dl, input logic [31:0] det);
		wr(OFS_CTRL, 32'h0000_0044);
		for (int a = 0; a < N_AXES; a++)
		begin
			wr(ra(4 * a + W_CMD), 32'(CMD_PPRESET));
			wr(ra(4 * a + W_ADR), 32'(a));
			wr(ra(4 * a + W_LO), dl);
			wr(ra(4 * a + W_HI), BUS_ZERO);
		end
		wr(OFS_CTRL, 32'h0000_0055);
		rc(OFS_STAT, 32'h0000_0055);
		for (int a = 0; a < N_AXES; a++)
		begin
			rc(OFS_RWORD + ra(4 * a + W_CMD), 32'(CMD_PPRESET));
			rc(OFS_RWORD + ra(4 * a + W_ADR), 32'(a));
			rc(OFS_RWORD + ra(4 * a + W_LO), dl);
			rc(OFS_RWORD + ra(4 * a + W_HI), BUS_ZERO);
		end
		wr(OFS_CTRL, 32'h0000_0044);
		rc(OFS_STAT, 32'h0000_0044);
		for (int a = 0; a < N_AXES; a++)
			rc(OFS_RWORD + ra(4 * a), det);
	endtask

	initial
	begin
		rst_i = 1'b1;
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		t_reset();
		t_monitor();
		t_write_pos();
		t_move();
		t_update();
		t_preset(32'h0000_0002, 32'h0000_1388);
		t_preset(32'h0000_0001, BUS_ZERO);
		wr(OFS_CTRL, BUS_ZERO);
		rc(OFS_STAT, BUS_ZERO);
		close_out();
	end
endmodule // fbrr_top_tb
